//--- hw/chan_cfg_params.svh
`ifndef CHAN_CFG_PARAMS_SVH
`define CHAN_CFG_PARAMS_SVH
// Channel addresses
`define A_RS_DEC    8'h90
`define A_RS_INT    8'h91
`define A_RS_SCALE  8'h92
`define A_RSVD_A    8'h93
`define A_F5_DEC    8'h94
`define A_F5_SCALE  8'h95
`define A_RSVD_B    8'h96
`define A_CF_DEC    8'ha0
`define A_CF_PHASE  8'ha1
`define A_CF_TAPS   8'ha2
`define A_CF_OFF    8'ha3
`define A_CF_CTL    8'ha4
`define A_SIG_I     8'ha5
`define A_SIG_Q     8'ha6
`define A_ST_COUNT  8'ha7
`define A_MT_CTL    8'ha8
`define A_OUT_CTL   8'ha9
// Register widths
`define W_RS_DEC    12
`define W_RS_INT    9
`define W_RS_SCALE  12
`define W_F5_DEC    8
`define W_F5_SCALE  5
`define W_CF        8
`define W_CF_CTL    11
`define W_SIG       16
`define W_ST_COUNT  20
`define W_MT        3
`define W_OUT_CTL   10
// Field positions
`define SC_INV      11
`define SC_WT       10
`define SC_QUIET    9:5
`define SC_LOUD     4:0
`define CTL_BYPASS  10
`define CTL_OTHER   9
`define CTL_BANK    8
`define CTL_COMEXP  7
`define CTL_FORCE   6
`define CTL_FMT     5:4
`define CTL_SCALE   3:0
`define OC_MAP      9
`define OC_WORD16   5
`define MT_EN       0
`define MT_CFAIL    1
`define MT_DFAIL    2
// Constants
`define EXP_STEP_LO 2'h1
`define EXP_STEP_HI 2'h2
`define MEMTEST_CYCLES 1600
`define SIG_TAPS    16'hb400
`endif

//--- hw/chan_cfg_pkg.sv
package chan_cfg_pkg;
  // Configuration seen by the filter datapaths
  typedef struct packed {
    logic [12:0] resample_decimation;
    logic [9:0]  resample_interpolation;
    logic        exp_invert;
    logic [1:0]  exp_step_bits;
    logic [4:0]  active_scale;
    logic [8:0]  fifth_comb_decimation;
    logic [4:0]  fifth_comb_attenuation;
    logic [8:0]  coef_filter_decimation;
    logic [7:0]  coef_filter_phase_select;
    logic [8:0]  coef_filter_taps;
    logic [7:0]  coef_memory_pointer;
    logic        filter_bypass;
    logic        input_other;
    logic        coef_bank;
    logic        common_exponent;
    logic        force_scale;
    logic [1:0]  out_format;
    logic [3:0]  out_scale;
    logic        par_word_16;
  } cfg_s;
  // One filter output sample
  typedef struct packed {
    logic        valid;
    logic [15:0] i;
    logic [15:0] q;
  } sample_s;
  typedef enum logic [2:0] {
    MT_IDLE = 3'b001,
    MT_RUN  = 3'b010,
    MT_DONE = 3'b100
  } mt_state_e;
endpackage

//--- hw/sig_accum.sv
`timescale 1ns/1ps
`include "chan_cfg_params.svh"
module sig_accum #(
  parameter int          W    = 16,
  parameter logic [W-1:0] TAPS = `SIG_TAPS
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_val_in,
  input  wire logic         step_in,
  input  wire logic         map_in,
  input  wire logic [W-1:0] data_in,
  output logic      [W-1:0] sig_out
);
  logic fb;
  assign fb = ^(sig_out & TAPS);
  // Software load wins; else fold sample into signature or capture it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_out <= '0;
    end else if (load_in) begin
      sig_out <= load_val_in;
    end else if (step_in) begin
      sig_out <= map_in ? data_in : ({sig_out[W-2:0], fb} ^ data_in);
    end
  end
endmodule

//--- hw/mem_test_seq.sv
`timescale 1ns/1ps
`include "chan_cfg_params.svh"
module mem_test_seq
  import chan_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start_in,
  input  wire logic       coef_storage_fail_in,
  input  wire logic       dmem_fail_in,
  output logic            busy_out,
  output logic            cfail_out,
  output logic            dfail_out
);
  mt_state_e   state_r;
  logic [10:0] cnt_r;
  // Sequencer: run a fixed window then return idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MT_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        MT_IDLE: if (start_in) begin
          state_r <= MT_RUN;
          cnt_r   <= '0;
        end
        MT_RUN: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == 11'(`MEMTEST_CYCLES - 1)) state_r <= MT_DONE;
        end
        MT_DONE: state_r <= MT_IDLE;
        default: state_r <= MT_IDLE;
      endcase
    end
  end
  assign busy_out = (state_r != MT_IDLE);
  // Failure flags: sticky during run, a start clears them and failures outside run are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfail_out <= 1'b0;
      dfail_out <= 1'b0;
    end else begin
      if (state_r == MT_RUN && coef_storage_fail_in) cfail_out <= 1'b1;
      else if (state_r == MT_IDLE && start_in) cfail_out <= 1'b0;
      if (state_r == MT_RUN && dmem_fail_in) dfail_out <= 1'b1;
      else if (state_r == MT_IDLE && start_in) dfail_out <= 1'b0;
    end
  end
endmodule

//--- hw/channel_filter_config_bank.sv
`timescale 1ns/1ps
`include "chan_cfg_params.svh"
// Notes on behaviour
// R01: Resample decimation register holds factor minus one; device uses value plus one.
// R02: Software keeps resample decimation within 1 to 4096.
// R03: Software keeps resample decimation above interpolation with a usable scale.
// R04: Resample interpolation register holds factor minus one, range 1 to 512.
// R05: Resample scale register feeds comb attenuation and exponent linearisation.
// R06: Scale bit 11 inverts input exponent polarity.
// R07: Scale bit 10 picks 6.02 or 12.02 dB per exponent step.
// R08: Quiet scale bits 9-5, loud bits 4-0, chosen by level indicator.
// R09: Software writes zero to reserved addresses 0x93 and 0x96.
// R10: Fifth-order comb decimation stored minus one; keep within 1 to 32.
// R11: Fifth-order comb scale bits 4-0 set growth attenuation.
// R12: Coefficient filter decimation stored minus one, up to 256.
// R13: Control bits 5-4 pick 12+4, 8+4 float or fixed output.
// R14: Bit 7 shares one exponent; bit 6 forces output scale.
// R15: Bit 8 coef bank, bit 10 bypass to signatures, bit 9 input source.
// R16: Separate 16-bit signature registers for I and Q paths.
// R17: 20-bit count sets accumulated outputs; read returns live counter.
// R18: Memory test: bit 0 enable, bit 1 coef fail, bit 2 data fail.
// R19: Output control bit 9 maps output data into signature registers.
// R20: Output control bit 5 picks 16-bit or 12-bit parallel words.
// R21: Tap-count register holds taps minus one; device uses plus one.
// R22: Software starts memory test asleep, waits 1600 clocks, polls fails.
// R23: Unused addresses between the comb and coef registers ignore writes, read zero.
// R24: Each register keeps only its width; upper bits read zero.
module channel_filter_config_bank
  import chan_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               resetn_in,
  // Channel address port
  input  wire logic [7:0]         chan_addr_in,
  input  wire logic               wr_en_in,
  input  wire logic               rd_en_in,
  input  wire logic [19:0]        wr_data_in,
  output logic      [19:0]        rd_data_out,
  output logic                    rd_valid_out,
  // Datapath status
  input  wire logic               level_indicator_in,
  input  wire chan_cfg_pkg::sample_s filter_sample_in,
  input  wire chan_cfg_pkg::sample_s comb5_sample_in,
  input  wire logic               coef_storage_fail_in,
  input  wire logic               dmem_fail_in,
  // Configuration and test status
  output chan_cfg_pkg::cfg_s      cfg_out,
  output logic                    selftest_busy_out,
  output logic                    mem_test_busy_out
);
  import chan_cfg_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  logic [`W_RS_DEC-1:0]   rs_dec_r;
  logic [`W_RS_INT-1:0]   rs_int_r;
  logic [`W_RS_SCALE-1:0] rs_scale_r;
  logic [`W_F5_DEC-1:0]   f5_dec_r;
  logic [`W_F5_SCALE-1:0] f5_scale_r;
  logic [`W_CF-1:0]       cf_dec_r;
  logic [`W_CF-1:0]       cf_phase_r;
  logic [`W_CF-1:0]       cf_taps_r;
  logic [`W_CF-1:0]       cf_off_r;
  logic [`W_CF_CTL-1:0]   cf_ctl_r;
  logic [`W_OUT_CTL-1:0]  oc_r;
  logic [`W_ST_COUNT-1:0] st_count_r;
  logic [`W_SIG-1:0]      sig_i;
  logic [`W_SIG-1:0]      sig_q;
  logic [19:0]            rd_nxt;
  sample_s                src;
  logic                   step;
  logic                   map_mode;
  logic                   mt_start;
  logic                   mt_busy;
  logic                   mt_cfail;
  logic                   mt_dfail;
  logic                   wr_sig_i;
  logic                   wr_sig_q;

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Resampling comb registers, width-trimmed on write
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rs_dec_r   <= '0;
      rs_int_r   <= '0;
      rs_scale_r <= '0;
    end else if (wr_en_in) begin
      case (chan_addr_in)
        `A_RS_DEC:   rs_dec_r   <= wr_data_in[`W_RS_DEC-1:0];   // R01 R24
        `A_RS_INT:   rs_int_r   <= wr_data_in[`W_RS_INT-1:0];   // R04 R24
        `A_RS_SCALE: rs_scale_r <= wr_data_in[`W_RS_SCALE-1:0]; // R05 R24
        default: ;
      endcase
    end
  end

  // Fifth-order comb registers; reserved neighbours hold nothing
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      f5_dec_r   <= '0;
      f5_scale_r <= '0;
    end else if (wr_en_in) begin
      case (chan_addr_in)
        `A_F5_DEC:   f5_dec_r   <= wr_data_in[`W_F5_DEC-1:0];   // R10
        `A_F5_SCALE: f5_scale_r <= wr_data_in[`W_F5_SCALE-1:0]; // R11 R24
        default: ;                                               // R23
      endcase
    end
  end

  // Coefficient filter registers
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cf_dec_r   <= '0;
      cf_phase_r <= '0;
      cf_taps_r  <= '0;
      cf_off_r   <= '0;
      cf_ctl_r   <= '0;
    end else if (wr_en_in) begin
      case (chan_addr_in)
        `A_CF_DEC:   cf_dec_r   <= wr_data_in[`W_CF-1:0];     // R12
        `A_CF_PHASE: cf_phase_r <= wr_data_in[`W_CF-1:0];
        `A_CF_TAPS:  cf_taps_r  <= wr_data_in[`W_CF-1:0];     // R21
        `A_CF_OFF:   cf_off_r   <= wr_data_in[`W_CF-1:0];
        `A_CF_CTL:   cf_ctl_r   <= wr_data_in[`W_CF_CTL-1:0]; // R24
        default: ;
      endcase
    end
  end

  // Output control register
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      oc_r <= '0;
    end else if (wr_en_in && chan_addr_in == `A_OUT_CTL) begin
      oc_r <= wr_data_in[`W_OUT_CTL-1:0]; // R24
    end
  end

  // Signature source: bypass routes comb output past the filter
  assign src      = cf_ctl_r[`CTL_BYPASS] ? comb5_sample_in : filter_sample_in; // R15
  assign map_mode = oc_r[`OC_MAP];                                              // R19
  assign step     = src.valid && (map_mode || st_count_r != '0);                // R17
  assign wr_sig_i = wr_en_in && chan_addr_in == `A_SIG_I;
  assign wr_sig_q = wr_en_in && chan_addr_in == `A_SIG_Q;

  // Output counter: write loads and starts, each sample outside map mode counts down until zero
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_count_r <= '0;
    end else if (wr_en_in && chan_addr_in == `A_ST_COUNT) begin
      st_count_r <= wr_data_in[`W_ST_COUNT-1:0]; // R17
    end else if (src.valid && !map_mode && st_count_r != '0) begin
      st_count_r <= st_count_r - 20'h0_0001;     // R17
    end
  end

  // I and Q signature registers
  sig_accum #(
    .W    (`W_SIG),
    .TAPS (`SIG_TAPS)
  ) u_sig_i (
    .clk         (ref_clk_in),
    .rst_n       (rst_n),
    .load_in     (wr_sig_i),
    .load_val_in (wr_data_in[`W_SIG-1:0]),
    .step_in     (step),
    .map_in      (map_mode),
    .data_in     (src.i),
    .sig_out     (sig_i)
  ); // R16

  sig_accum #(
    .W    (`W_SIG),
    .TAPS (`SIG_TAPS)
  ) u_sig_q (
    .clk         (ref_clk_in),
    .rst_n       (rst_n),
    .load_in     (wr_sig_q),
    .load_val_in (wr_data_in[`W_SIG-1:0]),
    .step_in     (step),
    .map_in      (map_mode),
    .data_in     (src.q),
    .sig_out     (sig_q)
  ); // R16

  // Memory test sequencer
  assign mt_start = wr_en_in && chan_addr_in == `A_MT_CTL && wr_data_in[`MT_EN]; // R18

  mem_test_seq u_mem_test (
    .clk          (ref_clk_in),
    .rst_n        (rst_n),
    .start_in     (mt_start),
    .coef_storage_fail_in (coef_storage_fail_in),
    .dmem_fail_in (dmem_fail_in),
    .busy_out     (mt_busy),
    .cfail_out    (mt_cfail),
    .dfail_out    (mt_dfail)
  );

  // Read mux; unused and reserved addresses return zero
  always_comb begin
    rd_nxt = 20'h0_0000;
    case (chan_addr_in)
      `A_RS_DEC:   rd_nxt = 20'(rs_dec_r);   // R24
      `A_RS_INT:   rd_nxt = 20'(rs_int_r);
      `A_RS_SCALE: rd_nxt = 20'(rs_scale_r);
      `A_F5_DEC:   rd_nxt = 20'(f5_dec_r);
      `A_F5_SCALE: rd_nxt = 20'(f5_scale_r); // R24
      `A_CF_DEC:   rd_nxt = 20'(cf_dec_r);
      `A_CF_PHASE: rd_nxt = 20'(cf_phase_r);
      `A_CF_TAPS:  rd_nxt = 20'(cf_taps_r);
      `A_CF_OFF:   rd_nxt = 20'(cf_off_r);
      `A_CF_CTL:   rd_nxt = 20'(cf_ctl_r);
      `A_SIG_I:    rd_nxt = 20'(sig_i);      // R16 R19
      `A_SIG_Q:    rd_nxt = 20'(sig_q);
      `A_ST_COUNT: rd_nxt = st_count_r;      // R17
      `A_MT_CTL:   rd_nxt = 20'({mt_dfail, mt_cfail, mt_busy}); // R18
      `A_OUT_CTL:  rd_nxt = 20'(oc_r);
      default:     rd_nxt = 20'h0_0000;      // R23
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) rd_data_out <= rd_nxt;
    end
  end

  // Resampling comb configuration
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_out.resample_decimation    <= '0;
      cfg_out.resample_interpolation <= '0;
      cfg_out.exp_invert             <= 1'b0;
      cfg_out.exp_step_bits          <= `EXP_STEP_LO;
      cfg_out.active_scale           <= '0;
    end else begin
      cfg_out.resample_decimation    <= 13'(rs_dec_r) + 13'h0001; // R01
      cfg_out.resample_interpolation <= 10'(rs_int_r) + 10'h001;  // R04
      cfg_out.exp_invert             <= rs_scale_r[`SC_INV];      // R06
      cfg_out.exp_step_bits          <= rs_scale_r[`SC_WT] ? `EXP_STEP_HI
                                                           : `EXP_STEP_LO; // R07
      cfg_out.active_scale           <= level_indicator_in ? rs_scale_r[`SC_QUIET]
                                                           : rs_scale_r[`SC_LOUD]; // R08
    end
  end

  // Fifth-order comb and coefficient filter configuration
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_out.fifth_comb_decimation    <= '0;
      cfg_out.fifth_comb_attenuation   <= '0;
      cfg_out.coef_filter_decimation   <= '0;
      cfg_out.coef_filter_phase_select <= '0;
      cfg_out.coef_filter_taps         <= '0;
      cfg_out.coef_memory_pointer      <= '0;
    end else begin
      cfg_out.fifth_comb_decimation    <= 9'(f5_dec_r) + 9'h001;  // R10
      cfg_out.fifth_comb_attenuation   <= f5_scale_r;             // R11
      cfg_out.coef_filter_decimation   <= 9'(cf_dec_r) + 9'h001;  // R12
      cfg_out.coef_filter_phase_select <= cf_phase_r;
      cfg_out.coef_filter_taps         <= 9'(cf_taps_r) + 9'h001; // R21
      cfg_out.coef_memory_pointer      <= cf_off_r;
    end
  end

  // Output formatting and test status
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_out.filter_bypass   <= 1'b0;
      cfg_out.input_other     <= 1'b0;
      cfg_out.coef_bank       <= 1'b0;
      cfg_out.common_exponent <= 1'b0;
      cfg_out.force_scale     <= 1'b0;
      cfg_out.out_format      <= '0;
      cfg_out.out_scale       <= '0;
      cfg_out.par_word_16     <= 1'b0;
      selftest_busy_out       <= 1'b0;
      mem_test_busy_out       <= 1'b0;
    end else begin
      cfg_out.filter_bypass   <= cf_ctl_r[`CTL_BYPASS]; // R15
      cfg_out.input_other     <= cf_ctl_r[`CTL_OTHER];  // R15
      cfg_out.coef_bank       <= cf_ctl_r[`CTL_BANK];   // R15
      cfg_out.common_exponent <= cf_ctl_r[`CTL_COMEXP]; // R14
      cfg_out.force_scale     <= cf_ctl_r[`CTL_FORCE];  // R14
      cfg_out.out_format      <= cf_ctl_r[`CTL_FMT];    // R13
      cfg_out.out_scale       <= cf_ctl_r[`CTL_SCALE];
      cfg_out.par_word_16     <= oc_r[`OC_WORD16];      // R20
      selftest_busy_out       <= st_count_r != '0;
      mem_test_busy_out       <= mt_busy;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  AST_RS_DEC_PLUS_ONE: assert property ( // R01
    wr_en_in && chan_addr_in == `A_RS_DEC |-> ##2
      cfg_out.resample_decimation == 13'($past(wr_data_in[`W_RS_DEC-1:0], 2)) + 13'h0001)
    else $error("resample decimation not written value plus one");

  AST_RS_INT_PLUS_ONE: assert property ( // R04
    wr_en_in && chan_addr_in == `A_RS_INT |-> ##2
      cfg_out.resample_interpolation == 10'($past(wr_data_in[`W_RS_INT-1:0], 2)) + 10'h001)
    else $error("resample interpolation not written value plus one");

  AST_SCALE_SELECT: assert property ( // R08
    cfg_out.active_scale == $past(level_indicator_in ? rs_scale_r[`SC_QUIET]
                                                      : rs_scale_r[`SC_LOUD]))
    else $error("active scale does not follow level indicator");

  AST_UNUSED_READ_ZERO: assert property ( // R23
    rd_en_in && chan_addr_in > `A_RSVD_B && chan_addr_in < `A_CF_DEC
      |=> rd_valid_out && rd_data_out == 20'h0_0000)
    else $error("unused address read not zero");

  AST_WIDTH_TRIM: assert property ( // R24
    rd_en_in && chan_addr_in == `A_F5_SCALE |=> rd_data_out[19:`W_F5_SCALE] == '0)
    else $error("bits above register width read nonzero");

  AST_FORMAT_FOLLOWS: assert property ( // R13
    !$stable(cf_ctl_r[`CTL_FMT]) |=> cfg_out.out_format == $past(cf_ctl_r[`CTL_FMT]))
    else $error("output format not propagated");

  AST_COUNT_DOWN: assert property ( // R17
    src.valid && !map_mode && st_count_r != '0 && !wr_en_in
      |=> st_count_r == $past(st_count_r) - 20'h0_0001)
    else $error("self-test count did not decrement");

  AST_MAP_CAPTURE: assert property ( // R19
    map_mode && src.valid && !wr_sig_i && !wr_sig_q
      |=> sig_i == $past(src.i) && sig_q == $past(src.q))
    else $error("mapped output not captured in signatures");

  AST_WORD_LENGTH: assert property ( // R20
    wr_en_in && chan_addr_in == `A_OUT_CTL |-> ##2
      cfg_out.par_word_16 == $past(wr_data_in[`OC_WORD16], 2))
    else $error("parallel word length not applied");

  AST_MEMTEST_BUSY: assert property ( // R18
    mt_start && !mt_busy |=> mt_busy [*8])
    else $error("memory test did not stay busy");

  COV_RS_WRITE: cover property (wr_en_in && chan_addr_in == `A_RS_DEC);
  COV_COUNT_DONE: cover property (st_count_r == 20'h0_0001 ##1 st_count_r == '0);
  COV_MEMTEST_DONE: cover property ($fell(mt_busy));
  COV_MAP_CAPTURE: cover property (map_mode && src.valid);
endmodule

//--- verification/channel_filter_config_bank_bench.sv
`timescale 1ns/1ps
`include "chan_cfg_params.svh"
module channel_filter_config_bank_bench;
  import chan_cfg_pkg::*;
  logic       ref_clk_in, resetn_in, wr_en_in, rd_en_in, rd_valid_out;
  logic       level_indicator_in, coef_storage_fail_in, dmem_fail_in;
  logic       selftest_busy_out, mem_test_busy_out;
  logic [7:0] chan_addr_in;
  logic [19:0] wr_data_in, rd_data_out;
  sample_s    filter_sample_in, comb5_sample_in;
  cfg_s       cfg_out;
  int         n_mismatch, total_checks;

  channel_filter_config_bank u_channel_filter_config_bank (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .chan_addr_in(chan_addr_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .level_indicator_in(level_indicator_in), .filter_sample_in(filter_sample_in),
    .comb5_sample_in(comb5_sample_in), .coef_storage_fail_in(coef_storage_fail_in), .dmem_fail_in(dmem_fail_in),
    .cfg_out(cfg_out), .selftest_busy_out(selftest_busy_out),
    .mem_test_busy_out(mem_test_busy_out));

  // Clock at 8 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes and reads start and end just after a falling edge
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    chan_addr_in = a; wr_data_in = d; wr_en_in = 1'b1;
    @(negedge ref_clk_in); wr_en_in = 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [19:0] e);
    chan_addr_in = a; rd_en_in = 1'b1;
    @(negedge ref_clk_in); rd_en_in = 1'b0;
    chk("rd_valid", rd_valid_out, 1'b1);
    chk($sformatf("read %h", a), rd_data_out, e);
    @(negedge ref_clk_in);
  endtask

  task automatic pulse(input logic [15:0] i, input logic [15:0] q);
    filter_sample_in = {1'b1, i, q};
    @(negedge ref_clk_in); filter_sample_in.valid = 1'b0;
  endtask

  function automatic logic [15:0] sstep(input logic [15:0] s, input logic [15:0] d);
    return {s[14:0], ^(s & 16'hb400)} ^ d;
  endfunction

  // Stored zero after reset, used as one
  task automatic t_reset();
    chk("dec", cfg_out.resample_decimation, 13'h1);
    chk("int", cfg_out.resample_interpolation, 10'h1);
    chk("taps", cfg_out.coef_filter_taps, 9'h1);
    chk("step", cfg_out.exp_step_bits, `EXP_STEP_LO);
  endtask

  // All-ones write: width clipping and plus-one use
  task automatic t_widths();
    logic [7:0] ad[8] = '{8'h90, 8'h91, 8'h94, 8'h95, 8'ha0, 8'ha1, 8'ha2, 8'ha3};
    logic [19:0] mk[8] = '{20'hfff, 20'h1ff, 20'hff, 20'h1f, 20'hff, 20'hff, 20'hff, 20'hff};
    foreach (ad[k]) wr(ad[k], 20'hfffff);
    foreach (ad[k]) rdchk(ad[k], mk[k]);
    chk("rs_dec", cfg_out.resample_decimation, 13'h1000);
    chk("rs_int", cfg_out.resample_interpolation, 10'h200);
    chk("f5_dec", cfg_out.fifth_comb_decimation, 9'h100);
    chk("f5_sc", cfg_out.fifth_comb_attenuation, 5'h1f);
    chk("cf_dec", cfg_out.coef_filter_decimation, 9'h100);
    chk("phase", cfg_out.coef_filter_phase_select, 8'hff);
    chk("taps", cfg_out.coef_filter_taps, 9'h100);
    chk("ptr", cfg_out.coef_memory_pointer, 8'hff);
  endtask

  // Scale fields and level-driven choice
  task automatic t_scale();
    wr(8'h92, 20'h0d55);
    rdchk(8'h92, 20'h0d55);
    chk("inv", cfg_out.exp_invert, 1'b1);
    chk("wt", cfg_out.exp_step_bits, `EXP_STEP_HI);
    level_indicator_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk("quiet", cfg_out.active_scale, 5'h0a);
    level_indicator_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("loud", cfg_out.active_scale, 5'h15);
    wr(8'h92, 20'h0000);
    chk("wt0", cfg_out.exp_step_bits, `EXP_STEP_LO);
  endtask

  // Reserved and unused places stay zero
  task automatic t_reserved();
    logic [7:0] ad[4] = '{8'h93, 8'h96, 8'h97, 8'h9f};
    foreach (ad[k]) wr(ad[k], (k < 2) ? 20'h0 : 20'hfffff);
    foreach (ad[k]) rdchk(ad[k], 20'h0);
  endtask

  // Coefficient filter control fields
  task automatic t_ctl();
    wr(8'ha4, 20'hff5a6);
    rdchk(8'ha4, 20'h5a6);
    chk("ctl", {cfg_out.filter_bypass, cfg_out.input_other, cfg_out.coef_bank,
                cfg_out.common_exponent, cfg_out.force_scale, cfg_out.out_format,
                cfg_out.out_scale}, 11'h5a6);
    wr(8'ha4, 20'h240);
    chk("ctl2", {cfg_out.input_other, cfg_out.force_scale, cfg_out.out_format}, 4'hc);
    wr(8'ha4, 20'h0);
  endtask

  // Signature accumulation over a counted run
  task automatic t_selftest();
    logic [15:0] si, sq;
    si = 16'h1357; sq = 16'h2468;
    wr(8'ha5, 20'h1357); wr(8'ha6, 20'h2468); wr(8'ha7, 20'h2);
    rdchk(8'ha7, 20'h2);
    chk("busy", selftest_busy_out, 1'b1);
    pulse(16'h00f0, 16'h0f00); si = sstep(si, 16'h00f0); sq = sstep(sq, 16'h0f00);
    rdchk(8'ha7, 20'h1);
    pulse(16'h8001, 16'h7ffe); si = sstep(si, 16'h8001); sq = sstep(sq, 16'h7ffe);
    pulse(16'hffff, 16'hffff);
    rdchk(8'ha7, 20'h0);
    chk("idle", selftest_busy_out, 1'b0);
    rdchk(8'ha5, {4'h0, si});
    rdchk(8'ha6, {4'h0, sq});
  endtask

  // Raw output mapped into signatures, word length bit
  task automatic t_map();
    wr(8'ha9, 20'hfffff);
    rdchk(8'ha9, 20'h3ff);
    chk("w16", cfg_out.par_word_16, 1'b1);
    pulse(16'h1234, 16'habcd);
    rdchk(8'ha5, 20'h1234);
    rdchk(8'ha6, 20'habcd);
    wr(8'ha9, 20'h0);
    chk("w12", cfg_out.par_word_16, 1'b0);
  endtask

  // Bypass sends comb output, not filter output, to mapped signatures
  task automatic t_bypass();
    wr(8'ha4, 20'h400);
    wr(8'ha9, 20'h200);
    comb5_sample_in = {1'b1, 16'h5a5a, 16'hc3c3};
    filter_sample_in = {1'b1, 16'h1111, 16'h2222};
    @(negedge ref_clk_in);
    comb5_sample_in.valid = 1'b0;
    filter_sample_in.valid = 1'b0;
    rdchk(8'ha5, 20'h5a5a);
    rdchk(8'ha6, 20'hc3c3);
    wr(8'ha9, 20'h0);
    wr(8'ha4, 20'h0);
  endtask

  // Memory test window and fail reporting
  task automatic t_mem(input logic cf, input logic df, input logic [19:0] e);
    int n;
    coef_storage_fail_in = cf; dmem_fail_in = df;
    wr(8'ha8, 20'h1);
    chk("mbusy", mem_test_busy_out, 1'b1);
    n = 0;
    while (mem_test_busy_out === 1'b1) begin
      @(negedge ref_clk_in);
      n++;
      if (n > 2000) begin
        chk("mem_timeout", 1'b0, 1'b1);
        end_sim();
      end
    end
    chk("mlen", (n >= 1597 && n <= 1602), 1'b1);
    coef_storage_fail_in = 1'b0; dmem_fail_in = 1'b0;
    rdchk(8'ha8, e);
  endtask

  initial begin
    n_mismatch = 0; total_checks = 0;
    resetn_in = 1'b0; wr_en_in = 1'b0; rd_en_in = 1'b0; chan_addr_in = 8'h00;
    wr_data_in = 20'h0; level_indicator_in = 1'b0; coef_storage_fail_in = 1'b0;
    dmem_fail_in = 1'b0; filter_sample_in = '0; comb5_sample_in = '0;
    repeat (5) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    t_reset();
    t_widths();
    t_scale();
    t_reserved();
    t_ctl();
    t_selftest();
    t_map();
    t_bypass();
    t_mem(1'b1, 1'b0, 20'h2);
    t_mem(1'b0, 1'b1, 20'h4);
    end_sim();
  end
endmodule
